// >>> tb/plane_memory_model.sv
// Four-plane video memory model on the plane port
`timescale 1ns/1ps
module plane_memory_model (
  input wire logic clk_i,               // Clock
  input wire logic [15:0] plane_addr_i, // Plane address
  input wire logic [3:0] plane_we_i,    // Plane write enables
  input wire logic plane_rd_i,          // Read pulse
  input wire logic [31:0] plane_wdata_i, // Write data
  output logic [31:0] plane_rdata_o     // Read data
);
  logic [31:0] mem [16];
  initial begin
    mem[1] = 32'h44332211;
  end
  // Outside a read the bus shows inverted data, so a late sample cannot pass
  assign plane_rdata_o = plane_rd_i ? mem[plane_addr_i[3:0]] : ~mem[plane_addr_i[3:0]];
  always @(posedge clk_i) begin
    for (int n = 0; n < 4; n++) begin
      if (plane_we_i[n]) begin
        mem[plane_addr_i[3:0]][8*n +: 8] <= plane_wdata_i[8*n +: 8];
      end
    end
  end
endmodule

// >>> tb/vga_planar_memory_datapath_monitor.sv
// Port-level checker for the planar memory datapath
`timescale 1ns/1ps
module vga_planar_memory_datapath_monitor (
  input wire logic clk_i,             // Clock
  input wire logic reset_i,           // Reset
  input wire logic io_rd_i,           // I/O read strobe
  input wire logic io_data_port_i,    // Port select
  input wire logic [7:0] io_rdata_o,  // I/O read data
  input wire logic mem_rd_i,          // Memory read strobe
  input wire logic mem_wr_i,          // Memory write strobe
  input wire logic [19:0] mem_addr_i, // CPU address
  input wire logic mem_hit_o,         // Window hit
  input wire logic mem_rvalid_o,      // Read valid
  input wire logic [3:0] plane_we_o,  // Plane write enables
  input wire logic plane_rd_o,        // Plane read pulse
  input wire logic disp_shift_i,      // Display shift
  input wire logic [3:0] disp_pixel_o // Pixel out
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  AST_WR_ISSUE: assert property (mem_wr_i && mem_hit_o |=> plane_we_o != 4'h0)
    else $error("write hit gave no plane write");
  AST_RD_ISSUE: assert property (mem_rd_i && mem_hit_o |=> plane_rd_o && plane_we_o == 4'h0)
    else $error("read hit gave no plane read");
  AST_RVALID: assert property (plane_rd_o |=> mem_rvalid_o ##1 !mem_rvalid_o)
    else $error("read data valid not a single pulse after plane read");
  AST_RVALID_SRC: assert property (mem_rvalid_o |-> $past(plane_rd_o))
    else $error("read data valid without plane read");
  AST_MISS: assert property (!(mem_hit_o && (mem_wr_i || mem_rd_i)) |=>
    plane_we_o == 4'h0 && !plane_rd_o)
    else $error("plane access without a taken request");
  AST_WINDOW: assert property (mem_addr_i < 20'hA0000 || mem_addr_i > 20'hBFFFF |-> !mem_hit_o)
    else $error("hit outside every window");
  AST_PAIR: assert property (plane_we_o inside {4'h0, 4'h5, 4'hA, 4'hF})
    else $error("plane enables outside legal pairs");
  AST_INDEX_RD: assert property (io_rd_i && !io_data_port_i |=> io_rdata_o[7:4] == 4'h0)
    else $error("index read upper bits not zero");
  AST_IO_HOLD: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("io read data changed without read");
  AST_PIXEL_HOLD: assert property (!disp_shift_i |=> $stable(disp_pixel_o))
    else $error("pixel changed without shift");
endmodule
bind vga_planar_memory_datapath vga_planar_memory_datapath_monitor mon (.clk_i(clk_i),
  .reset_i(reset_i), .io_rd_i(io_rd_i), .io_data_port_i(io_data_port_i),
  .io_rdata_o(io_rdata_o), .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i), .mem_addr_i(mem_addr_i),
  .mem_hit_o(mem_hit_o), .mem_rvalid_o(mem_rvalid_o), .plane_we_o(plane_we_o),
  .plane_rd_o(plane_rd_o), .disp_shift_i(disp_shift_i), .disp_pixel_o(disp_pixel_o));

// >>> tb/vga_planar_memory_datapath_tb_top.sv
// Self-checking bench for the planar memory datapath
`timescale 1ns/1ps
module vga_planar_memory_datapath_tb_top;
  import gfx_datapath_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic io_data_port_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic mem_rd_i = 1'b0;
  logic mem_wr_i = 1'b0;
  logic [19:0] mem_addr_i = 20'hA0000;
  logic [7:0] mem_wdata_i = 8'h00;
  logic disp_load_i = 1'b0;
  logic disp_shift_i = 1'b0;
  logic [31:0] disp_data_i = 32'h40FF0080;
  logic [7:0] io_rdata_o, mem_rdata_o;
  logic mem_hit_o, mem_rvalid_o, plane_rd_o, char_latch_en_o;
  logic [15:0] plane_addr_o;
  logic [3:0] plane_we_o, disp_pixel_o;
  logic [31:0] plane_wdata_o, plane_rdata_i;
  logic [19:0] probe [8] = '{20'h9FFFF, 20'hA0000, 20'hAFFFF, 20'hB0000, 20'hB7FFF,
    20'hB8000, 20'hBFFFF, 20'hC0000};
  logic [7:0] rmask [4] = '{8'h03, 8'h7B, 8'h0F, 8'h0F};
  logic [7:0] ccol [4] = '{8'h05, 8'h02, 8'h09, 8'h08};
  logic [7:0] cdc [4] = '{8'h0F, 8'h03, 8'h00, 8'h08};
  logic [7:0] cexp [4] = '{8'h11, 8'h22, 8'hFF, 8'h44};
  logic [7:0] smode [3] = '{8'h00, 8'h20, 8'h60};
  logic [3:0] sexp [3] = '{4'h5, 4'hD, 4'h8};
  int miscompares = 0;
  int n_tests = 0;

  initial forever #2.5 clk_i = ~clk_i;

  vga_planar_memory_datapath DUT (.clk_i(clk_i), .reset_i(reset_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_data_port_i(io_data_port_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i),
    .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i), .mem_hit_o(mem_hit_o),
    .mem_rdata_o(mem_rdata_o), .mem_rvalid_o(mem_rvalid_o), .plane_addr_o(plane_addr_o),
    .plane_we_o(plane_we_o), .plane_rd_o(plane_rd_o), .plane_wdata_o(plane_wdata_o),
    .plane_rdata_i(plane_rdata_i), .disp_load_i(disp_load_i), .disp_shift_i(disp_shift_i),
    .disp_data_i(disp_data_i), .disp_pixel_o(disp_pixel_o),
    .char_latch_en_o(char_latch_en_o));
  plane_memory_model mem_model (.clk_i(clk_i), .plane_addr_i(plane_addr_o),
    .plane_we_i(plane_we_o), .plane_rd_i(plane_rd_o), .plane_wdata_i(plane_wdata_o),
    .plane_rdata_o(plane_rdata_i));

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic io(input logic p, input logic [7:0] d);
    @(posedge clk_i);
    io_wr_i <= 1'b1;
    io_data_port_i <= p;
    io_wdata_i <= d;
    @(posedge clk_i);
    io_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic p, input logic [7:0] e);
    @(posedge clk_i);
    io_rd_i <= 1'b1;
    io_data_port_i <= p;
    @(posedge clk_i);
    io_rd_i <= 1'b0;
    #1;
    chk("io_rdata_o", {24'h0, e}, {24'h0, io_rdata_o});
  endtask
  task automatic rw(input logic [7:0] idx, input logic [7:0] d);
    io(1'b0, idx);
    io(1'b1, d);
  endtask
  task automatic rr(input logic [7:0] idx, input logic [7:0] e);
    io(1'b0, idx);
    rd(1'b1, e);
  endtask
  task automatic mwr(input logic [19:0] a, input logic [7:0] d, input logic [3:0] we,
      input logic [31:0] wd);
    @(posedge clk_i);
    mem_wr_i <= 1'b1;
    mem_addr_i <= a;
    mem_wdata_i <= d;
    @(posedge clk_i);
    mem_wr_i <= 1'b0;
    #1;
    chk("plane_we_o", {28'h0, we}, {28'h0, plane_we_o});
    chk("plane_wdata_o", wd, plane_wdata_o);
  endtask
  task automatic mrd(input logic [19:0] a, input logic [7:0] e);
    @(posedge clk_i);
    mem_rd_i <= 1'b1;
    mem_addr_i <= a;
    @(posedge clk_i);
    mem_rd_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("mem_rvalid_o", 32'h1, {31'h0, mem_rvalid_o});
    chk("mem_rdata_o", {24'h0, e}, {24'h0, mem_rdata_o});
  endtask
  function automatic logic hitf(input int m, input logic [19:0] a);
    case (m)
      0: return a >= 20'hA0000 && a <= 20'hBFFFF;
      1: return a >= 20'hA0000 && a <= 20'hAFFFF;
      2: return a >= 20'hB0000 && a <= 20'hB7FFF;
      default: return a >= 20'hB8000 && a <= 20'hBFFFF;
    endcase
  endfunction
  function automatic logic [31:0] ropf(input int r);
    return r == 0 ? 32'h0F0F0F0F : r == 1 ? 32'h04030201 : r == 2 ? 32'h4F3F2F1F : 32'h4B3C2D1E;
  endfunction

  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    chk("char_latch_en_o", 32'h1, {31'h0, char_latch_en_o});
    rr(8'h05, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rw(8'(i + 4), 8'hFF);
      rr(8'(i + 4), rmask[i]);
    end
    rw(8'h09, 8'hFF);
    rr(8'h09, 8'h00);
    io(1'b0, 8'hF7);
    rd(1'b0, 8'h07);
    rw(8'h06, 8'h05);
    rw(8'h05, 8'h00);
    rw(8'h08, 8'hFF);
    rw(8'h03, 8'h00);
    rw(8'h01, 8'h00);
    mwr(20'hA0000, 8'h3C, 4'hF, 32'h3C3C3C3C);
    rw(8'h03, 8'h03);
    rw(8'h01, 8'h05);
    rw(8'h00, 8'h01);
    mwr(20'hA0000, 8'h81, 4'hF, 32'h300030FF);
    rw(8'h03, 8'h00);
    rw(8'h01, 8'h00);
    for (int s = 0; s < 4; s++) begin
      rw(8'h04, 8'(s));
      mrd(20'hA0001, 8'(32'h44332211 >> (8 * s)));
    end
    rw(8'h05, 8'h01);
    rw(8'h03, 8'h1F);
    rw(8'h08, 8'h00);
    mwr(20'hA0002, 8'hFF, 4'hF, 32'h44332211);
    rw(8'h05, 8'h00);
    rw(8'h03, 8'h00);
    rw(8'h08, 8'h0F);
    mwr(20'hA0002, 8'hFF, 4'hF, 32'h4F3F2F1F);
    rw(8'h08, 8'hFF);
    for (int r = 0; r < 4; r++) begin
      rw(8'h03, 8'(r * 8));
      mwr(20'hA0002, 8'h0F, 4'hF, ropf(r));
    end
    rw(8'h03, 8'h00);
    rw(8'h05, 8'h02);
    rw(8'h08, 8'hF0);
    mwr(20'hA0002, 8'h05, 4'hF, 32'h04F302F1);
    rw(8'h05, 8'h03);
    rw(8'h00, 8'h0A);
    rw(8'h08, 8'hFF);
    mwr(20'hA0002, 8'h3C, 4'hF, 32'h7C033E01);
    rw(8'h05, 8'h08);
    rw(8'h04, 8'h03);
    for (int k = 0; k < 4; k++) begin
      rw(8'h02, ccol[k]);
      rw(8'h07, cdc[k]);
      mrd(20'hA0001, cexp[k]);
    end
    // Sequencer side taken as programmed to the inverse setting
    rw(8'h05, 8'h10);
    mwr(20'hA0003, 8'h00, 4'hA, 32'h0);
    mwr(20'hA0004, 8'h00, 4'h5, 32'h0);
    rw(8'h04, 8'h02);
    mrd(20'hA0001, 8'h44);
    rw(8'h04, 8'h01);
    mrd(20'hA0002, 8'h01);
    rw(8'h05, 8'h00);
    rw(8'h06, 8'h07);
    mwr(20'hA0005, 8'h00, 4'hA, 32'h0);
    chk("plane_addr_o", 32'h4, {16'h0, plane_addr_o});
    for (int m = 0; m < 4; m++) begin
      rw(8'h06, 8'(m * 4 + m % 2));
      #1;
      chk("char_latch_en_o", 32'(1 - m % 2), {31'h0, char_latch_en_o});
      for (int j = 0; j < 8; j++) begin
        @(posedge clk_i);
        mem_addr_i <= probe[j];
        #1;
        chk("mem_hit_o", {31'h0, hitf(m, probe[j])}, {31'h0, mem_hit_o});
      end
    end
    for (int m = 0; m < 3; m++) begin
      rw(8'h05, smode[m]);
      @(posedge clk_i);
      disp_load_i <= 1'b1;
      @(posedge clk_i);
      disp_load_i <= 1'b0;
      disp_shift_i <= 1'b1;
      @(posedge clk_i);
      disp_shift_i <= 1'b0;
      #1;
      chk("disp_pixel_o", {28'h0, sexp[m]}, {28'h0, disp_pixel_o});
    end
    summarize();
  end
endmodule

// >>> verilog/display_shift_loader.sv
// Display shift registers with normal, interleaved and 256-colour loading
`timescale 1ns/1ps
module display_shift_loader (
  input wire logic clk_i,          // System clock
  input wire logic reset_i,        // Async reset, active high
  shift_link_if.loader link        // Load, shift and pixel link
);
  logic [7:0] plane_sr_reg [4];
  logic [3:0] pixel_reg;
  logic [3:0] pixel_next;

  always_comb begin
    if (link.colour256) begin
      // One 4-bit half of the plane 0 byte per shift, upper half first
      pixel_next = plane_sr_reg[0][7:4];
    end else if (link.interleave) begin
      // Odd bits onto even planes, even bits onto odd planes
      pixel_next = {plane_sr_reg[3][6], plane_sr_reg[2][7],
        plane_sr_reg[1][6], plane_sr_reg[0][7]};
    end else begin
      pixel_next = {plane_sr_reg[3][7], plane_sr_reg[2][7],
        plane_sr_reg[1][7], plane_sr_reg[0][7]};
    end
  end

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_plane
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          plane_sr_reg[p] <= 8'h00;
        end else if (link.load) begin
          plane_sr_reg[p] <= link.planes[8*p +: 8];
        end else if (link.shift) begin
          if (link.colour256) begin
            plane_sr_reg[p] <= {plane_sr_reg[p][3:0], 4'h0};
          end else if (link.interleave) begin
            plane_sr_reg[p] <= {plane_sr_reg[p][5:0], 2'h0};
          end else begin
            plane_sr_reg[p] <= {plane_sr_reg[p][6:0], 1'h0};
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pixel_reg <= 4'h0;
    end else if (link.shift) begin
      pixel_reg <= pixel_next;
    end
  end

  assign link.pixel = pixel_reg;
endmodule

// >>> verilog/gfx_datapath_pkg.sv
// Constants shared by the planar memory datapath modules
package gfx_datapath_pkg;
  // Register indices behind the index/data port pair
  localparam logic [3:0] FILL_VALUE_INDEX = 4'h0;
  localparam logic [3:0] FILL_ENABLE_INDEX = 4'h1;
  localparam logic [3:0] COMPARE_COLOUR_INDEX = 4'h2;
  localparam logic [3:0] ROTATE_ROP_INDEX = 4'h3;
  localparam logic [3:0] PLANE_SELECT_INDEX = 4'h4;
  localparam logic [3:0] MODE_INDEX = 4'h5;
  localparam logic [3:0] MEMORY_MAP_INDEX = 4'h6;
  localparam logic [3:0] DONT_CARE_INDEX = 4'h7;
  localparam logic [3:0] MASK_INDEX = 4'h8;
  // Writable bits per register; reserved bits read zero
  localparam logic [7:0] NIBBLE_BITS = 8'h0F;
  localparam logic [7:0] ROTATE_ROP_BITS = 8'h1F;
  localparam logic [7:0] PLANE_SELECT_BITS = 8'h03;
  localparam logic [7:0] MODE_BITS = 8'h7B;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions
  localparam int ROP_LSB = 3;
  localparam int READ_COMPARE_POS = 3;
  localparam int ODD_EVEN_POS = 4;
  localparam int INTERLEAVE_POS = 5;
  localparam int COLOUR256_POS = 6;
  localparam int TEXT_GRAPHICS_POS = 0;
  localparam int CHAIN_POS = 1;
  localparam int MAP_LSB = 2;
  // Write modes and raster operations
  localparam logic [1:0] WMODE_ROTATED = 2'h0;
  localparam logic [1:0] WMODE_LATCH = 2'h1;
  localparam logic [1:0] WMODE_COLOUR = 2'h2;
  localparam logic [1:0] WMODE_FILL = 2'h3;
  localparam logic [1:0] ROP_PASS = 2'h0;
  localparam logic [1:0] ROP_AND = 2'h1;
  localparam logic [1:0] ROP_OR = 2'h2;
  localparam logic [1:0] ROP_XOR = 2'h3;
  // CPU memory windows (20-bit byte addresses)
  localparam logic [19:0] WIN_A0000 = 20'hA0000;
  localparam logic [19:0] WIN_B0000 = 20'hB0000;
  localparam logic [19:0] WIN_B8000 = 20'hB8000;
  localparam logic [19:0] WIN_END_128K = 20'hBFFFF;
  localparam logic [19:0] WIN_END_64K = 20'hAFFFF;
  localparam logic [19:0] WIN_END_B0_32K = 20'hB7FFF;
  localparam logic [19:0] WIN_END_B8_32K = 20'hBFFFF;
  // Plane enables for even and odd addresses in odd/even schemes
  localparam logic [3:0] EVEN_PLANES = 4'h5;
  localparam logic [3:0] ODD_PLANES = 4'hA;
  localparam logic [3:0] ALL_PLANES = 4'hF;
endpackage

// >>> verilog/shift_link_if.sv
// Link between the datapath core and the display shift loader
`timescale 1ns/1ps
interface shift_link_if;
  logic load;
  logic shift;
  logic [31:0] planes;
  logic interleave;
  logic colour256;
  logic [3:0] pixel;
  modport core (output load, output shift, output planes, output interleave,
    output colour256, input pixel);
  modport loader (input load, input shift, input planes, input interleave,
    input colour256, output pixel);
endinterface

// >>> verilog/vga_planar_memory_datapath.sv
// Planar video memory datapath: register file, read and write paths
`timescale 1ns/1ps
// Behaviour
// - Read mode 0 returns the selected plane
// - Odd/even ignores low bit of plane select
// - Plane select unused in compare reads
// - Mode 0: rotated data or fill value
// - Mode 1: latches written, all else ignored
// - Mode 2: data bit n fills plane n
// - Mode 3: fill value, rotated data masks
// - Compare bit selects compare or plane read
// - Odd/even: even addresses planes 0,2
// - Interleaved shift splits even/odd bits
// - 256-colour shift overrides interleaved shift
// - Graphics addressing disables character latches
// - Chain replaces A0, A0 picks plane pair
// - Map field sets CPU decode window
// - Cleared don't-care bit excludes plane from compare
// - Cleared mask bit keeps latch bit
// - Every memory read inside the decode window loads the latches
// - Reserved register bits read zero
// - Rotate count right-rotates write data
// - Raster op combines with latches
// - Fill enable picks fill value per plane
// - Compare yields per-pixel colour match
module vga_planar_memory_datapath
  import gfx_datapath_pkg::*;
(
  input wire logic clk_i,             // System clock, 200 MHz
  input wire logic reset_i,           // Async reset, active high
  input wire logic io_wr_i,           // I/O write strobe
  input wire logic io_rd_i,           // I/O read strobe
  input wire logic io_data_port_i,    // 0 index port, 1 data port
  input wire logic [7:0] io_wdata_i,  // I/O write data
  output logic [7:0] io_rdata_o,      // I/O read data, registered
  input wire logic mem_rd_i,          // CPU memory read strobe
  input wire logic mem_wr_i,          // CPU memory write strobe
  input wire logic [19:0] mem_addr_i, // CPU memory byte address
  input wire logic [7:0] mem_wdata_i, // CPU memory write data
  output logic mem_hit_o,             // Address inside decode window
  output logic [7:0] mem_rdata_o,     // CPU memory read data
  output logic mem_rvalid_o,          // Read data valid pulse
  output logic [15:0] plane_addr_o,   // Plane memory address
  output logic [3:0] plane_we_o,      // Per-plane write enable pulse
  output logic plane_rd_o,            // Plane read pulse
  output logic [31:0] plane_wdata_o,  // Write data, plane n at [8n+7:8n]
  input wire logic [31:0] plane_rdata_i, // Read data, same layout
  input wire logic disp_load_i,       // Load display shift registers
  input wire logic disp_shift_i,      // Advance display shift registers
  input wire logic [31:0] disp_data_i, // Display fetch, four planes
  output logic [3:0] disp_pixel_o,    // Serial pixel stream
  output logic char_latch_en_o        // Character generator latch enable
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [3:0] index_reg;
  logic [3:0] fill_value_reg;
  logic [3:0] fill_enable_reg;
  logic [3:0] compare_colour_reg;
  logic [4:0] rotate_rop_reg;
  logic [1:0] read_plane_field;
  logic [6:0] mode_reg;
  logic [3:0] memory_map_reg;
  logic [3:0] dont_care_reg;
  logic [7:0] write_bit_mask;
  logic [7:0] reg_read;
  logic data_wr;

  assign data_wr = io_wr_i && io_data_port_i;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      index_reg <= 4'h0;
    end else if (io_wr_i && !io_data_port_i) begin
      index_reg <= io_wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fill_value_reg <= REG_RESET[3:0];
      fill_enable_reg <= REG_RESET[3:0];
      compare_colour_reg <= REG_RESET[3:0];
      rotate_rop_reg <= REG_RESET[4:0];
      read_plane_field <= REG_RESET[1:0];
      mode_reg <= REG_RESET[6:0];
      memory_map_reg <= REG_RESET[3:0];
      dont_care_reg <= REG_RESET[3:0];
      write_bit_mask <= REG_RESET;
    end else if (data_wr) begin
      unique case (index_reg)
        FILL_VALUE_INDEX: fill_value_reg <= io_wdata_i[3:0];
        FILL_ENABLE_INDEX: fill_enable_reg <= io_wdata_i[3:0];
        COMPARE_COLOUR_INDEX: compare_colour_reg <= io_wdata_i[3:0];
        ROTATE_ROP_INDEX: rotate_rop_reg <= io_wdata_i[4:0];
        PLANE_SELECT_INDEX: read_plane_field <= io_wdata_i[1:0];
        MODE_INDEX: mode_reg <= io_wdata_i[6:0] & MODE_BITS[6:0];
        MEMORY_MAP_INDEX: memory_map_reg <= io_wdata_i[3:0];
        DONT_CARE_INDEX: dont_care_reg <= io_wdata_i[3:0];
        MASK_INDEX: write_bit_mask <= io_wdata_i;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (index_reg)
      FILL_VALUE_INDEX: reg_read = {4'h0, fill_value_reg};
      FILL_ENABLE_INDEX: reg_read = {4'h0, fill_enable_reg};
      COMPARE_COLOUR_INDEX: reg_read = {4'h0, compare_colour_reg};
      ROTATE_ROP_INDEX: reg_read = {3'h0, rotate_rop_reg};
      PLANE_SELECT_INDEX: reg_read = {6'h00, read_plane_field};
      MODE_INDEX: reg_read = {1'h0, mode_reg} & MODE_BITS;
      MEMORY_MAP_INDEX: reg_read = {4'h0, memory_map_reg};
      DONT_CARE_INDEX: reg_read = {4'h0, dont_care_reg};
      MASK_INDEX: reg_read = write_bit_mask;
      default: reg_read = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i) begin
      io_rdata_o <= io_data_port_i ? reg_read : {4'h0, index_reg};
    end
  end

  // ----------------------------------------------------------------
  // Mode fields
  // ----------------------------------------------------------------
  logic [1:0] write_mode_field;
  logic read_compare_bit;
  logic odd_even_bit;
  logic chain_odd_even_bit;
  logic text_graphics_addressing_bit;
  logic [1:0] map_field;
  logic [2:0] rotate_count;
  logic [1:0] raster_op_field;

  assign write_mode_field = mode_reg[1:0];
  assign read_compare_bit = mode_reg[READ_COMPARE_POS];
  assign odd_even_bit = mode_reg[ODD_EVEN_POS];
  assign chain_odd_even_bit = memory_map_reg[CHAIN_POS];
  assign text_graphics_addressing_bit = memory_map_reg[TEXT_GRAPHICS_POS];
  assign map_field = memory_map_reg[MAP_LSB +: 2];
  assign rotate_count = rotate_rop_reg[2:0];
  assign raster_op_field = rotate_rop_reg[ROP_LSB +: 2];
  // Latch addresses are only meaningful in text display addressing
  assign char_latch_en_o = !text_graphics_addressing_bit;

  // ----------------------------------------------------------------
  // CPU window decode and plane addressing
  // ----------------------------------------------------------------
  logic [19:0] win_base;
  logic [19:0] win_end;
  logic [19:0] win_offset;
  logic [15:0] addr_next;
  logic [3:0] planes_next;
  logic pair_select;

  always_comb begin
    unique case (map_field)
      2'h0: begin
        win_base = WIN_A0000;
        win_end = WIN_END_128K;
      end
      2'h1: begin
        win_base = WIN_A0000;
        win_end = WIN_END_64K;
      end
      2'h2: begin
        win_base = WIN_B0000;
        win_end = WIN_END_B0_32K;
      end
      2'h3: begin
        win_base = WIN_B8000;
        win_end = WIN_END_B8_32K;
      end
    endcase
  end

  assign mem_hit_o = (mem_addr_i >= win_base) && (mem_addr_i <= win_end);
  assign win_offset = mem_addr_i - win_base;
  assign pair_select = win_offset[0];

  always_comb begin
    if (chain_odd_even_bit) begin
      // A0 steers the plane pair, so a higher bit takes its place
      addr_next = {win_offset[15:1], win_offset[16]};
    end else begin
      addr_next = win_offset[15:0];
    end
    if (chain_odd_even_bit || odd_even_bit) begin
      planes_next = pair_select ? ODD_PLANES : EVEN_PLANES;
    end else begin
      planes_next = ALL_PLANES;
    end
  end

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  logic [7:0] rotated;
  logic [7:0] eff_mask;
  logic [31:0] write_next;
  logic [31:0] latch_reg;

  // Doubling the byte makes a right rotate a plain slice
  assign rotated = 8'({mem_wdata_i, mem_wdata_i} >> rotate_count);
  assign eff_mask = (write_mode_field == WMODE_FILL) ?
    (rotated & write_bit_mask) : write_bit_mask;

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_plane
      logic [7:0] src;
      logic [7:0] rop;
      logic [7:0] latch_b;
      assign latch_b = latch_reg[8*p +: 8];
      always_comb begin
        unique case (write_mode_field)
          WMODE_ROTATED: src = fill_enable_reg[p] ?
            {8{fill_value_reg[p]}} : rotated;
          WMODE_COLOUR: src = {8{mem_wdata_i[p]}};
          WMODE_FILL: src = {8{fill_value_reg[p]}};
          default: src = latch_b;
        endcase
        unique case (raster_op_field)
          ROP_PASS: rop = src;
          ROP_AND: rop = src & latch_b;
          ROP_OR: rop = src | latch_b;
          ROP_XOR: rop = src ^ latch_b;
        endcase
        if (write_mode_field == WMODE_LATCH) begin
          write_next[8*p +: 8] = latch_b;
        end else begin
          write_next[8*p +: 8] = (rop & eff_mask) | (latch_b & ~eff_mask);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Memory request stage
  // ----------------------------------------------------------------
  logic read_pend_reg;
  logic [3:0] read_pair_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      plane_addr_o <= 16'h0000;
      plane_we_o <= 4'h0;
      plane_rd_o <= 1'b0;
      plane_wdata_o <= 32'h0000_0000;
      read_pend_reg <= 1'b0;
      read_pair_reg <= 4'h0;
    end else begin
      plane_we_o <= (mem_wr_i && mem_hit_o) ? planes_next : 4'h0;
      plane_rd_o <= mem_rd_i && mem_hit_o;
      read_pend_reg <= mem_rd_i && mem_hit_o;
      if (mem_hit_o && (mem_rd_i || mem_wr_i)) begin
        plane_addr_o <= addr_next;
        read_pair_reg <= planes_next;
      end
      if (mem_wr_i && mem_hit_o) begin
        plane_wdata_o <= write_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path and processor latches
  // ----------------------------------------------------------------
  logic [1:0] read_plane;
  logic [7:0] compare_result;
  logic [7:0] read_next;

  // Odd/even: the address picks the plane within the selected pair
  assign read_plane = (odd_even_bit || chain_odd_even_bit) ?
    {read_plane_field[1], read_pair_reg[1]} : read_plane_field;

  generate
    for (p = 0; p < 8; p++) begin : g_pixel
      logic [3:0] colour;
      assign colour = {plane_rdata_i[24 + p], plane_rdata_i[16 + p],
        plane_rdata_i[8 + p], plane_rdata_i[p]};
      assign compare_result[p] =
        &(~dont_care_reg | ~(colour ^ compare_colour_reg));
    end
  endgenerate

  assign read_next = read_compare_bit ? compare_result :
    plane_rdata_i[8*read_plane +: 8];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      latch_reg <= 32'h0000_0000;
    end else if (read_pend_reg) begin
      latch_reg <= plane_rdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mem_rdata_o <= 8'h00;
      mem_rvalid_o <= 1'b0;
    end else begin
      mem_rvalid_o <= read_pend_reg;
      if (read_pend_reg) begin
        mem_rdata_o <= read_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Display shift loading
  // ----------------------------------------------------------------
  shift_link_if link ();

  assign link.load = disp_load_i;
  assign link.shift = disp_shift_i;
  assign link.planes = disp_data_i;
  assign link.interleave = mode_reg[INTERLEAVE_POS];
  assign link.colour256 = mode_reg[COLOUR256_POS];
  assign disp_pixel_o = link.pixel;

  display_shift_loader u_shift (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .link(link)
  );
endmodule
